/* verilog/synth_latch_params.svh */
// Offsets, field positions, reset values and counts of the latch bank
`ifndef SYNTH_LATCH_PARAMS_SVH
`define SYNTH_LATCH_PARAMS_SVH

`define WORD_W          24
`define FIELD_LSB       2
`define SEL_CTRL        2'h0
`define SEL_REF         2'h1
`define SEL_DIV         2'h2
`define SEL_TEST        2'h3
`define PD_SYNC_BIT     21
`define PD_REQ_BIT      20
`define CTRL_GAIN_BIT   10
`define DIV_GAIN_BIT    21
`define CTRL_RST        22'h000000
`define DIV_RST         22'h000000
`define REF_RST         22'h000000
`define SYNC_PD_EDGES   2

`endif

/* verilog/synth_latch_pkg.sv */
// Types shared by the latch bank
package synth_latch_pkg;

   // Configuration word, bits 23..2
   typedef struct packed {
      logic [1:0] prescaler_sel;
      logic       powerdown_sync_sel;
      logic       powerdown_request;
      logic [2:0] pump_current_b;
      logic [2:0] pump_current_a;
      logic [1:0] out_power;
      logic       mute_until_locked;
      logic       pump_gain_select;
      logic       pump_tristate;
      logic       detector_polarity;
      logic [2:0] output_mux_sel;
      logic       counter_clear;
      logic [1:0] core_current;
   } ctrl_cfg_t;

   // Feedback divider word, bits 23..2
   typedef struct packed {
      logic        halved_feedback_choice;
      logic        half_rate_output;
      logic        pump_gain_select;
      logic [12:0] main_count;
      logic        spare_bit;
      logic [4:0]  swallow_count;
   } div_cfg_t;

   // Reference divider word, bits 23..2
   typedef struct packed {
      logic [1:0]  spare_bits;
      logic [1:0]  band_clock_div;
      logic        factory_test_bit;
      logic        lock_precision_sel;
      logic [1:0]  pulse_width;
      logic [13:0] ref_divide;
   } ref_cfg_t;

   // Power state
   typedef enum logic [3:0] {
      PD_INIT = 4'b0001,
      PD_RUN  = 4'b0010,
      PD_WAIT = 4'b0100,
      PD_SOFT = 4'b1000
   } pd_state_t;

   // Effects driven to the analog and counter sections
   typedef struct packed {
      logic powered_down;
      logic counters_hold;
      logic lock_det_clr;
      logic pump_hiz;
      logic rf_off;
      logic refbuf_off;
   } pd_out_t;

endpackage : synth_latch_pkg

/* verilog/pin_sync.sv */
// Two-flop synchroniser for a group of pin inputs
module pin_sync #(
   parameter int WIDTH = 4
) (
   // Clock, reset, enable
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             en,
   // Pins and synchronised copies
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_sync_out
);

   generate
      if (WIDTH < 1)
      begin : g_chk
         $error("pin_sync: WIDTH must be at least 1");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // One pair of flops per pin; first stage feeds only the second
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         logic meta_q;
         logic sync_q;
         always_ff @(posedge clk)
         begin
            if (srst)
            begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end
            else if (en)
            begin
               meta_q <= pin_in[i];
               sync_q <= meta_q;
            end
         end
         assign pin_sync_out[i] = sync_q;
      end
   endgenerate

endmodule : pin_sync

/* verilog/synth_serial_latch_bank.sv */
// Serially loaded configuration latches with power-down control
// Functional notes
// - 24-bit word shifted MSB first on shift clock rise, latched on strobe rise
// - Two LSBs of the word select the destination latch
// - Code 00 loads control latch; prescaler select in bits 23..22
// - Control bits 21 and 20 are the two power-down bits
// - Control bits 16..14 pump current A, bits 19..17 pump current B
// - Code 01 loads reference latch with divide, width, precision, band clock
// - Code 10 loads divider latch: swallow, main count, gain, halving bits
// - Pump gain follows whichever latch carrying it was written last
// - Control bit 4 holds reference and feedback counters in reset
// - First control write after power-up with request bit 20 clear leaves power-down
// - Power-down bits 0,1 (request set, sync clear) power down at once
// - Both power-down bits set: down on second reference output rise
// - Chip enable low disables the device regardless of power-down bits
// - Power-down holds counters at load state and clears lock detect
// - Power-down tristates pump, turns off output and reference buffer
// - Serial register keeps shifting and latching during power-down
// - Resume without divider change keeps band, no reselection
`include "synth_latch_params.svh"
module synth_serial_latch_bank #(
   parameter int SYNC_EDGES = `SYNC_PD_EDGES
) (
   // Clock, reset, enable
   input  wire logic                     clk,
   input  wire logic                     srst,
   input  wire logic                     en,
   // Serial pins
   input  wire logic                     ser_clk,
   input  wire logic                     ser_data,
   input  wire logic                     load_strobe,
   input  wire logic                     chip_en,
   // Reference divider output, same clock domain
   input  wire logic                     ref_div_out,
   // Latched configuration
   output synth_latch_pkg::ctrl_cfg_t    ctrl_cfg,
   output synth_latch_pkg::div_cfg_t     div_cfg,
   output synth_latch_pkg::ref_cfg_t     ref_cfg,
   output logic                          pump_gain,
   // Power and band status
   output synth_latch_pkg::pd_out_t      pd_out,
   output logic                          band_select,
   output logic                          band_stale
);

   generate
      if (SYNC_EDGES < 1 || SYNC_EDGES > 3)
      begin : g_chk
         $error("synth_serial_latch_bank: SYNC_EDGES out of range");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [3:0] pins_s;
   logic       sclk_s;
   logic       data_s;
   logic       le_s;
   logic       ce_s;

   pin_sync #(
      .WIDTH (4)
   ) u_sync (
      .clk          (clk),
      .srst         (srst),
      .en           (en),
      .pin_in       ({chip_en, load_strobe, ser_data, ser_clk}),
      .pin_sync_out (pins_s)
   );

   assign sclk_s = pins_s[0];
   assign data_s = pins_s[1];
   assign le_s   = pins_s[2];
   assign ce_s   = pins_s[3];

   ////////////////////////////////////////////////////////////////////////
   // State
   logic [`WORD_W-1:0]          sr_q,        sr_d;
   logic                        sclk_p_q,    sclk_p_d;
   logic                        le_p_q,      le_p_d;
   logic                        ref_p_q,     ref_p_d;
   synth_latch_pkg::ctrl_cfg_t  ctrl_q,      ctrl_d;
   synth_latch_pkg::div_cfg_t   div_q,       div_d;
   synth_latch_pkg::ref_cfg_t   ref_q,       ref_d;
   logic                        gain_q,      gain_d;
   synth_latch_pkg::pd_state_t  st_q,        st_d;
   logic [1:0]                  edge_cnt_q,  edge_cnt_d;
   synth_latch_pkg::pd_out_t    pdo_q,       pdo_d;
   logic                        band_sel_q,  band_sel_d;
   logic                        stale_q,     stale_d;

   logic                        sclk_rise;
   logic                        le_rise;
   logic                        ref_rise;
   logic [1:0]                  sel;
   logic                        down_now;

   assign sclk_rise = sclk_s & ~sclk_p_q;
   assign le_rise   = le_s & ~le_p_q;
   assign ref_rise  = ref_div_out & ~ref_p_q;
   assign sel       = sr_q[1:0];
   assign down_now  = pdo_q.powered_down;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb
   begin
      sr_d       = sr_q;
      sclk_p_d   = sclk_s;
      le_p_d     = le_s;
      ref_p_d    = ref_div_out;
      ctrl_d     = ctrl_q;
      div_d      = div_q;
      ref_d      = ref_q;
      gain_d     = gain_q;
      st_d       = st_q;
      edge_cnt_d = edge_cnt_q;
      band_sel_d = 1'b0;
      stale_d    = stale_q;

      // Shift register runs in every power state
      if (sclk_rise)
         sr_d = {sr_q[`WORD_W-2:0], data_s};

      // Sync power-down: count reference output rises
      if (st_q == synth_latch_pkg::PD_WAIT && ref_rise)
      begin
         if (edge_cnt_q == 2'(SYNC_EDGES - 1))
            st_d = synth_latch_pkg::PD_SOFT;
         else
            edge_cnt_d = edge_cnt_q + 2'h1;
      end

      // Transfer on strobe rise
      if (le_rise)
      begin
         case (sel)
            `SEL_CTRL:
            begin
               ctrl_d = sr_q[`WORD_W-1:`FIELD_LSB];
               gain_d = sr_q[`CTRL_GAIN_BIT];
               edge_cnt_d = 2'h0;
               if (!sr_q[`PD_REQ_BIT])
                  st_d = synth_latch_pkg::PD_RUN;
               else if (!sr_q[`PD_SYNC_BIT])
                  st_d = synth_latch_pkg::PD_SOFT;
               else if (st_q == synth_latch_pkg::PD_RUN)
                  st_d = synth_latch_pkg::PD_WAIT;
               else if (st_q != synth_latch_pkg::PD_WAIT)
                  st_d = synth_latch_pkg::PD_SOFT;
            end
            `SEL_REF:
               ref_d = sr_q[`WORD_W-1:`FIELD_LSB];
            `SEL_DIV:
            begin
               div_d  = sr_q[`WORD_W-1:`FIELD_LSB];
               gain_d = sr_q[`DIV_GAIN_BIT];
               // Band reselect only while running; else band is stale
               if (down_now)
                  stale_d = 1'b1;
               else
               begin
                  band_sel_d = 1'b1;
                  stale_d    = 1'b0;
               end
            end
            default:
               ;
         endcase
      end

      // Power-down effects follow the next state and chip enable
      pdo_d.powered_down = ~ce_s
                         | st_d == synth_latch_pkg::PD_INIT
                         | st_d == synth_latch_pkg::PD_SOFT;
      pdo_d.counters_hold = pdo_d.powered_down
                          | ctrl_d.counter_clear;
      pdo_d.lock_det_clr  = pdo_d.powered_down;
      pdo_d.pump_hiz      = pdo_d.powered_down
                          | ctrl_d.pump_tristate;
      pdo_d.rf_off        = pdo_d.powered_down;
      pdo_d.refbuf_off    = pdo_d.powered_down;
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         sr_q       <= '0;
         sclk_p_q   <= 1'b0;
         le_p_q     <= 1'b0;
         ref_p_q    <= 1'b0;
         ctrl_q     <= `CTRL_RST;
         div_q      <= `DIV_RST;
         ref_q      <= `REF_RST;
         gain_q     <= 1'b0;
         st_q       <= synth_latch_pkg::PD_INIT;
         edge_cnt_q <= 2'h0;
         pdo_q      <= '1;
         band_sel_q <= 1'b0;
         stale_q    <= 1'b0;
      end
      else if (en)
      begin
         sr_q       <= sr_d;
         sclk_p_q   <= sclk_p_d;
         le_p_q     <= le_p_d;
         ref_p_q    <= ref_p_d;
         ctrl_q     <= ctrl_d;
         div_q      <= div_d;
         ref_q      <= ref_d;
         gain_q     <= gain_d;
         st_q       <= st_d;
         edge_cnt_q <= edge_cnt_d;
         pdo_q      <= pdo_d;
         band_sel_q <= band_sel_d;
         stale_q    <= stale_d;
      end
   end

   assign ctrl_cfg    = ctrl_q;
   assign div_cfg     = div_q;
   assign ref_cfg     = ref_q;
   assign pump_gain   = gain_q;
   assign pd_out      = pdo_q;
   assign band_select = band_sel_q;
   assign band_stale  = stale_q;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   shift_in_a: assert property (en && sclk_rise |=> sr_q[0] == $past(data_s)
      && sr_q[23:1] == $past(sr_q[22:0]))
      else $error("shift register did not take the bit");

   ctrl_load_a: assert property (en && le_rise && sel == 2'h0
      |=> ctrl_q == $past(sr_q[23:2]))
      else $error("control latch not loaded");

   ref_load_a: assert property (en && le_rise && sel == 2'h1
      |=> ref_q == $past(sr_q[23:2]) && ctrl_q == $past(ctrl_q))
      else $error("reference latch not loaded");

   div_load_a: assert property (en && le_rise && sel == 2'h2
      |=> div_q == $past(sr_q[23:2]) && ref_q == $past(ref_q))
      else $error("divider latch not loaded");

   test_code_a: assert property (en && le_rise && sel == 2'h3
      |=> $stable(ctrl_q) && $stable(div_q) && $stable(ref_q))
      else $error("select code 11 changed a latch");

   gain_latest_a: assert property (en && le_rise && sel == 2'h2
      |=> pump_gain == $past(sr_q[21]))
      else $error("pump gain not from last write");

   async_pd_a: assert property (en && le_rise && sel == 2'h0
      && sr_q[20] && !sr_q[21] |=> pd_out.powered_down && pd_out.rf_off)
      else $error("immediate power-down missed");

   sync_pd_a: assert property (en && st_q == synth_latch_pkg::PD_WAIT
      && ref_rise && edge_cnt_q == 2'(SYNC_EDGES - 1) && !le_rise
      |=> st_q == synth_latch_pkg::PD_SOFT)
      else $error("synchronous power-down not on second edge");

   ce_off_a: assert property (en && !ce_s |=> pd_out.powered_down)
      else $error("chip enable low did not disable");

   pd_effects_a: assert property (pd_out.powered_down |-> pd_out.pump_hiz
      && pd_out.counters_hold && pd_out.lock_det_clr
      && pd_out.refbuf_off)
      else $error("power-down effect missing");

   clear_hold_a: assert property (ctrl_q.counter_clear
      |-> pd_out.counters_hold)
      else $error("counter clear not holding counters");

endmodule : synth_serial_latch_bank

/* verification/host_serial_model.sv */
// Host controller model driving the three-wire programming pins
module host_serial_model (
   // Clock
   input  wire logic clk,
   // Serial pins
   output logic      ser_clk,
   output logic      ser_data,
   output logic      load_strobe
);
   timeunit 1ns;
   timeprecision 1ps;

   // Pins idle low, shift clock stands still between frames
   initial
   begin
      ser_clk     = 1'b0;
      ser_data    = 1'b0;
      load_strobe = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shift one word MSB first, data set 4 cycles before each rise, clock high 4 cycles, then strobe
   task automatic send_word(input logic [23:0] word);
      for (int i = 23; i >= 0; i--)
      begin
         @(negedge clk);
         ser_data = word[i];
         repeat (4) @(negedge clk);
         ser_clk = 1'b1;
         repeat (4) @(negedge clk);
         ser_clk = 1'b0;
      end
      repeat (4) @(negedge clk);
      ser_data    = ~ser_data; // Data no longer valid after the frame
      load_strobe = 1'b1;
      repeat (4) @(negedge clk);
      load_strobe = 1'b0;
   endtask : send_word

endmodule : host_serial_model

/* verification/synth_serial_latch_bank_tb.sv */
// Self-checking bench for the serial latch bank
module synth_serial_latch_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int SETTLE_CYCLES = 50; // Shortened host settle wait
   localparam int MAX_CYCLES    = 40000;

   // Clock, control pins and outputs
   logic                       clk = 1'b0;
   logic                       srst;
   logic                       en;
   logic                       chip_en;
   logic                       ref_div_out;
   wire logic                  ser_clk;
   wire logic                  ser_data;
   wire logic                  load_strobe;
   synth_latch_pkg::ctrl_cfg_t ctrl_cfg;
   synth_latch_pkg::div_cfg_t  div_cfg;
   synth_latch_pkg::ref_cfg_t  ref_cfg;
   synth_latch_pkg::pd_out_t   pd_out;
   logic                       pump_gain;
   logic                       band_select;
   logic                       band_stale;
   logic [21:0]                exp_ctrl;
   logic [21:0]                exp_div;
   logic [21:0]                exp_ref;
   logic                       exp_gain;
   logic [23:0]                w;
   int                         failures;
   int                         tests_run;
   int                         cycles;
   int                         pulses;

   always #2 clk = ~clk;

   host_serial_model host (
      .clk         (clk),
      .ser_clk     (ser_clk),
      .ser_data    (ser_data),
      .load_strobe (load_strobe)
   );

   synth_serial_latch_bank #(.SYNC_EDGES(2)) uut (
      .clk         (clk),
      .srst        (srst),
      .en          (en),
      .ser_clk     (ser_clk),
      .ser_data    (ser_data),
      .load_strobe (load_strobe),
      .chip_en     (chip_en),
      .ref_div_out (ref_div_out),
      .ctrl_cfg    (ctrl_cfg),
      .div_cfg     (div_cfg),
      .ref_cfg     (ref_cfg),
      .pump_gain   (pump_gain),
      .pd_out      (pd_out),
      .band_select (band_select),
      .band_stale  (band_stale)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Hang guard and band selection pulse count
   always @(posedge clk)
   begin
      cycles++;
      if (band_select === 1'b1)
         pulses++;
      if (cycles == MAX_CYCLES)
      begin
         failures++;
         end_of_test();
      end
   end

   task automatic check(input logic [23:0] seen, input logic [23:0] exp_v);
      tests_run++;
      if (seen !== exp_v)
      begin
         failures++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp_v);
      end
   endtask : check

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_of_test

   // Power effects while running: only clear and tristate bits pass through
   function automatic logic [23:0] pd_run(input logic [21:0] c);
      return {18'h0, 1'b0, c[2], 1'b0, c[7], 2'h0};
   endfunction : pd_run

   // Random word with a given select code, control words stay powered up
   function automatic logic [23:0] rnd_word(input logic [1:0] code);
      logic [23:0] r;
      r = 24'($urandom);
      r[1:0] = code;
      if (code == 2'h0)
         r[20] = 1'b0;
      // Reserved and test bits are written as zero by the host
      if (code == 2'h2)
         r[7] = 1'b0;
      if (code == 2'h1)
      begin
         r[23:22] = 2'h0;
         r[19]    = 1'b0;
      end
      return r;
   endfunction : rnd_word

   ////////////////////////////////////////////////////////////////////////////
   // Send a word, track the expected latches and compare them
   task automatic send(input logic [23:0] v);
      host.send_word(v);
      repeat (3) @(negedge clk);
      if (v[1:0] == 2'h0)
         exp_ctrl = v[23:2];
      if (v[1:0] == 2'h1)
         exp_ref = v[23:2];
      if (v[1:0] == 2'h2)
         exp_div = v[23:2];
      if (v[1:0] == 2'h0)
         exp_gain = v[10];
      if (v[1:0] == 2'h2)
         exp_gain = v[21];
      check({2'h0, ctrl_cfg}, {2'h0, exp_ctrl});
      check({2'h0, ref_cfg}, {2'h0, exp_ref});
      check({2'h0, div_cfg}, {2'h0, exp_div});
      check({23'h0, pump_gain}, {23'h0, exp_gain});
      if (v[1:0] == 2'h0 && v[20] == 1'b0)
         check({18'h0, pd_out}, pd_run(exp_ctrl));
   endtask : send

   task automatic ref_pulse();
      ref_div_out = 1'b1;
      @(negedge clk);
      ref_div_out = 1'b0;
      repeat (2) @(negedge clk);
   endtask : ref_pulse

   // Power-up order: reference, control, settle wait, divider
   task automatic power_up_sequence();
      send(rnd_word(2'h1));
      send(rnd_word(2'h0));
      repeat (SETTLE_CYCLES) @(negedge clk);
      send(rnd_word(2'h2));
   endtask : power_up_sequence

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      srst        = 1'b1;
      en          = 1'b1;
      chip_en     = 1'b1;
      ref_div_out = 1'b0;
      failures    = 0;
      tests_run   = 0;
      cycles      = 0;
      pulses      = 0;
      exp_ctrl    = 22'h0;
      exp_div     = 22'h0;
      exp_ref     = 22'h0;
      exp_gain    = 1'b0;
      w           = 24'($urandom(33));
      repeat (2) @(negedge clk);
      srst = 1'b0;
      @(negedge clk);
      check({18'h0, pd_out}, 24'h3f);
      // Bring-up with counter clear set, then one band selection
      send(rnd_word(2'h1));
      w = rnd_word(2'h0);
      w[4] = 1'b1;
      send(w);
      repeat (SETTLE_CYCLES) @(negedge clk);
      send(rnd_word(2'h2));
      check(24'(pulses), 24'h1);
      // Random traffic over all select codes, test code included
      repeat (12)
         send(rnd_word(2'($urandom_range(3, 0))));
      // Corner case: a test-code word must leave every latch alone
      send(rnd_word(2'h3));
      // Immediate power-down; latches keep loading while down
      w = rnd_word(2'h0);
      w[21:20] = 2'h1;
      send(w);
      check({18'h0, pd_out}, 24'h3f);
      send(rnd_word(2'h1));
      pulses = 0;
      send(rnd_word(2'h2));
      check({band_stale, 23'(pulses)}, 24'h800000);
      power_up_sequence();
      check({23'h0, band_stale}, 24'h0);
      // Synchronous power-down on the second reference rise
      w = rnd_word(2'h0);
      w[21:20] = 2'h3;
      send(w);
      check({18'h0, pd_out}, pd_run(exp_ctrl));
      ref_pulse();
      check({18'h0, pd_out}, pd_run(exp_ctrl));
      ref_pulse();
      check({18'h0, pd_out}, 24'h3f);
      // Resume without divider change, then chip enable drop
      pulses = 0;
      send(rnd_word(2'h0));
      check({band_stale, 23'(pulses)}, 24'h0);
      // Clock enable low freezes the pin synchronisers and power state
      en      = 1'b0;
      chip_en = 1'b0;
      repeat (5) @(negedge clk);
      check({18'h0, pd_out}, pd_run(exp_ctrl));
      en = 1'b1;
      repeat (5) @(negedge clk);
      check({18'h0, pd_out}, 24'h3f);
      chip_en = 1'b1;
      repeat (5) @(negedge clk);
      check({18'h0, pd_out}, pd_run(exp_ctrl));
      end_of_test();
   end

endmodule : synth_serial_latch_bank_tb
